// ===== shared/uab_defines.vh
/*
  Constants of the auto-baud measurement block: register byte
  addresses on APB, field positions, reset values and counts.
  Assumes a 32-bit APB with word-aligned registers.
*/
`ifndef UAB_DEFINES_VH
`define UAB_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define UAB_ADDR_SCRATCH   32'h4000_801C
`define UAB_ADDR_CONTROL   32'h4000_8020
`define UAB_ADDR_DIVISOR   32'h4000_8040
`define UAB_ADDR_IRQ_EN    32'h4000_8044
`define UAB_ADDR_IRQ_ID    32'h4000_8048
`define UAB_ADDR_FRAC      32'h4000_804C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UAB_CTL_START      0
`define UAB_CTL_MODE       1
`define UAB_CTL_RESTART    2
`define UAB_CTL_END_CLR    8
`define UAB_CTL_TO_CLR     9

// ----------------------------------------------------------------
// Interrupt enable and identification fields
// ----------------------------------------------------------------
`define UAB_IRQ_END        0
`define UAB_IRQ_TO         1
`define UAB_ID_BUSY        2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define UAB_SCRATCH_RST    8'h00
`define UAB_DIVISOR_RST    16'h0001
`define UAB_FRAC_RST       4'h0
`define UAB_PRESCALE_LAST  4'hF
`define UAB_FAST_PULSES    5'h10
`define UAB_COUNT_MAX      16'hFFFF

`endif

// ===== rtl/uab_autobaud.v
/*
  Auto-baud rate measurement for a UART receiver, with the scratch
  byte register, all reached over APB.
  Also holds the divisor latches, the interrupt enables and flags and
  the fractional add value, so every result can be read back.
  Assumes rxd comes straight from a pin (synchronised here) and that
  the receive shift register outside obeys rsr_clear, rsr_fast and
  rsr_sample_pulse. The counter is sixteen bits of pclk/16 ticks, so
  the slowest measurable bit lasts about a million pclk cycles in mode 1, half that in mode 0.
*/
// Decided for this implementation: the APB slave port.
`include "uab_defines.vh"

module uab_autobaud (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        rxd,
  output reg         rsr_clear,
  output reg         rsr_fast,
  output reg         rsr_sample_pulse,
  output wire [7:0]  divisor_low_latch,
  output wire [7:0]  divisor_high_latch,
  output wire        frac_enable,
  output wire        end_irq_flag,
  output wire        timeout_irq_flag
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  // Idle, awaiting the start edge, timing the start bit, and timing
  // the least significant bit in the fall-to-fall method
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_FALL  = 2'b01;
  localparam [1:0] ST_RISE  = 2'b10;
  localparam [1:0] ST_FALL2 = 2'b11;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function is_mapped;
    input [31:0] a;
    begin
      is_mapped = (a == `UAB_ADDR_SCRATCH) ||
                  (a == `UAB_ADDR_CONTROL) ||
                  (a == `UAB_ADDR_DIVISOR) ||
                  (a == `UAB_ADDR_IRQ_EN) ||
                  (a == `UAB_ADDR_IRQ_ID) ||
                  (a == `UAB_ADDR_FRAC);
    end
  endfunction

  wire access = psel & penable;
  wire wr_en  = access & pwrite & is_mapped(paddr);

  // One compare per writable register, shared by the write strobes below
  wire hit_scratch = (paddr == `UAB_ADDR_SCRATCH);
  wire hit_control = (paddr == `UAB_ADDR_CONTROL);
  wire hit_divisor = (paddr == `UAB_ADDR_DIVISOR);
  wire hit_irq_en  = (paddr == `UAB_ADDR_IRQ_EN);
  wire hit_frac    = (paddr == `UAB_ADDR_FRAC);

  wire wr_scratch  = wr_en & hit_scratch;
  wire wr_ctl      = wr_en & hit_control;
  wire wr_divisor  = wr_en & hit_divisor;
  wire wr_irq_en   = wr_en & hit_irq_en;
  wire wr_frac     = wr_en & hit_frac;

  // Every register answers within its single access cycle, so no
  // wait state is ever inserted
  assign pready  = 1'b1;
  assign pslverr = access & ~is_mapped(paddr);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]  scratch_reg;
  reg         start_reg;
  reg         mode_reg;
  reg         restart_reg;
  reg  [15:0] divisor_reg;
  reg         end_en_reg;
  reg         to_en_reg;
  reg         end_flag_reg;
  reg         to_flag_reg;
  reg  [3:0]  frac_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [15:0] count_reg;
  reg  [3:0]  presc_reg;
  reg  [4:0]  pulse_reg;
  reg         rx_meta_reg;
  reg         rx_sync_reg;
  reg         rx_prev_reg;
  reg  [31:0] rdata_next;

  // ----------------------------------------------------------------
  // Receive pin synchroniser and edges
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rxd;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // The third flop only remembers the last synchronised level; the
  // first stage feeds nothing but the second
  wire rx_fall = rx_prev_reg & ~rx_sync_reg;
  wire rx_rise = ~rx_prev_reg & rx_sync_reg;

  // ----------------------------------------------------------------
  // Measurement sequencing
  // ----------------------------------------------------------------
  // Software start and stop, seen on the write edge
  wire sw_start = wr_ctl & pwdata[`UAB_CTL_START] & ~start_reg;
  wire sw_stop  = wr_ctl & ~pwdata[`UAB_CTL_START];

  // The prescaler restarts with every run, so the first tick falls a
  // full sixteen cycles after the start edge
  wire counting = (state_reg == ST_RISE) || (state_reg == ST_FALL2);
  wire tick     = counting && (presc_reg == `UAB_PRESCALE_LAST);
  // Sixteen bits of ticks set the slowest rate that can be measured;
  // the sixteen-cycle prescaler tick sets the fastest
  wire overflow = tick && (count_reg == `UAB_COUNT_MAX);

  // Mode 0 spans start bit plus LSB, so halve it for one bit time
  wire [15:0] measured = mode_reg ? count_reg
                                  : {1'b0, count_reg[15:1]};

  // Overflow on the closing tick beats the closing edge, so a run
  // never loads a wrapped count
  wire done_m0 = (state_reg == ST_FALL2) && rx_fall && !overflow;
  wire done_m1 = (state_reg == ST_RISE) && mode_reg && rx_rise &&
                 !overflow;
  wire done    = done_m0 | done_m1;
  wire abort   = overflow & ~restart_reg;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sw_start)
          state_next = ST_FALL;
      end
      ST_FALL: begin
        if (rx_fall)
          state_next = ST_RISE;
      end
      ST_RISE: begin
        if (rx_rise)
          state_next = mode_reg ? ST_IDLE : ST_FALL2;
      end
      ST_FALL2: begin
        if (rx_fall)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (overflow)
      state_next = restart_reg ? ST_FALL : ST_IDLE;
    if (sw_stop)
      state_next = ST_IDLE;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      count_reg <= 16'h0000;
      presc_reg <= 4'h0;
      pulse_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      if (sw_start || overflow) begin
        count_reg <= 16'h0000;
        presc_reg <= 4'h0;
      end else if (state_reg == ST_FALL) begin
        count_reg <= 16'h0000;
        presc_reg <= 4'h0;
      end else if (counting) begin
        presc_reg <= presc_reg + 4'h1;
        if (tick)
          count_reg <= count_reg + 16'h0001;
      end
      // Burst of fast sampling pulses from the start edge
      if (state_reg == ST_FALL && rx_fall)
        pulse_reg <= `UAB_FAST_PULSES;
      else if (pulse_reg != 5'h00 && state_reg != ST_IDLE)
        pulse_reg <= pulse_reg - 5'h01;
      else
        pulse_reg <= 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Shift register controls
  // ----------------------------------------------------------------
  // The shift register keeps its normal rate outside a run, so a
  // stopped run hands the receiver straight back to the latches.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr_clear        <= 1'b0;
      rsr_fast         <= 1'b0;
      rsr_sample_pulse <= 1'b0;
    end else begin
      rsr_clear        <= sw_start;
      rsr_fast         <= (state_next != ST_IDLE);
      rsr_sample_pulse <= (pulse_reg != 5'h00) &&
                          (state_reg != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Control, latches and flags
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg    <= 1'b0;
      mode_reg     <= 1'b0;
      restart_reg  <= 1'b0;
      divisor_reg  <= `UAB_DIVISOR_RST;
      end_en_reg   <= 1'b0;
      to_en_reg    <= 1'b0;
      end_flag_reg <= 1'b0;
      to_flag_reg  <= 1'b0;
      frac_reg     <= `UAB_FRAC_RST;
      scratch_reg  <= `UAB_SCRATCH_RST;
    end else begin
      if (wr_scratch)
        scratch_reg <= pwdata[7:0];
      if (wr_irq_en) begin
        end_en_reg <= pwdata[`UAB_IRQ_END];
        to_en_reg  <= pwdata[`UAB_IRQ_TO];
      end
      // Kept so software can hold the fractional stage off during a run
      if (wr_frac)
        frac_reg <= pwdata[3:0];
      if (wr_ctl) begin
        mode_reg    <= pwdata[`UAB_CTL_MODE];
        restart_reg <= pwdata[`UAB_CTL_RESTART];
      end
      // An ending run beats a rewrite of the start bit; otherwise the
      // bit would read as pending with nothing left to clear it
      if (done || abort)
        start_reg <= 1'b0;
      else if (wr_ctl)
        start_reg <= pwdata[`UAB_CTL_START];
      // Hardware result wins over a software write in the same cycle
      if (done)
        divisor_reg <= measured;
      else if (wr_divisor)
        divisor_reg <= pwdata[15:0];
      // Setting beats clearing when both land together
      if (done && end_en_reg)
        end_flag_reg <= 1'b1;
      else if (wr_ctl && pwdata[`UAB_CTL_END_CLR])
        end_flag_reg <= 1'b0;
      if (overflow && to_en_reg)
        to_flag_reg <= 1'b1;
      else if (wr_ctl && pwdata[`UAB_CTL_TO_CLR])
        to_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  // The word is built here and registered once, so prdata holds
  // steady through the whole access phase
  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `UAB_ADDR_SCRATCH: rdata_next[7:0] = scratch_reg;
      `UAB_ADDR_CONTROL: begin
        rdata_next[`UAB_CTL_START]   = start_reg;
        rdata_next[`UAB_CTL_MODE]    = mode_reg;
        rdata_next[`UAB_CTL_RESTART] = restart_reg;
      end
      `UAB_ADDR_DIVISOR: rdata_next[15:0] = divisor_reg;
      `UAB_ADDR_IRQ_EN: begin
        rdata_next[`UAB_IRQ_END] = end_en_reg;
        rdata_next[`UAB_IRQ_TO]  = to_en_reg;
      end
      `UAB_ADDR_IRQ_ID: begin
        rdata_next[`UAB_IRQ_END] = end_flag_reg;
        rdata_next[`UAB_IRQ_TO]  = to_flag_reg;
        rdata_next[`UAB_ID_BUSY] = (state_reg != ST_IDLE);
      end
      `UAB_ADDR_FRAC: rdata_next[3:0] = frac_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rdata_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign divisor_low_latch  = divisor_reg[7:0];
  assign divisor_high_latch = divisor_reg[15:8];
  // Zero add value bypasses the fractional stage entirely
  assign frac_enable        = (frac_reg != 4'h0);
  assign end_irq_flag       = end_flag_reg;
  assign timeout_irq_flag   = to_flag_reg;

endmodule // uab_autobaud

// ===== bench/uab_autobaud_asserts.sv
/* Port checker for the auto-baud block.
   Assumes APB access phases and one pclk domain. */
`include "uab_defines.vh"
module uab_autobaud_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        rsr_clear,
  input wire logic        rsr_fast,
  input wire logic        rsr_sample_pulse,
  input wire logic [7:0]  divisor_low_latch,
  input wire logic [7:0]  divisor_high_latch,
  input wire logic        frac_enable,
  input wire logic        end_irq_flag,
  input wire logic        timeout_irq_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic wr = psel & penable & pwrite;
  wire logic ctl = wr && paddr == `UAB_ADDR_CONTROL;
  logic [4:0] pulse_cnt;
  // Pulses since the last start, so a seventeenth is caught
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pulse_cnt <= 5'h00;
    else if (rsr_clear) pulse_cnt <= 5'h00;
    else if (rsr_sample_pulse) pulse_cnt <= pulse_cnt + 5'h01;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_START: assert property (
    ctl && pwdata[0] && !rsr_fast |-> ##[1:2] rsr_clear ##[0:2] rsr_fast)
    else $error("start did not clear and speed up");
  AST_STOP: assert property (
    ctl && !pwdata[0] |-> ##[1:2] !rsr_fast)
    else $error("stop did not end run");
  AST_PULSES: assert property (
    pulse_cnt <= 5'h10) else $error("too many sample pulses");
  AST_PULSE_RUN: assert property (
    rsr_sample_pulse |-> rsr_fast) else $error("pulse outside run");
  AST_SCRATCH: assert property (
    wr && paddr == `UAB_ADDR_SCRATCH && !rsr_fast |=>
    $stable(end_irq_flag) && $stable(timeout_irq_flag))
    else $error("scratch access moved a flag");
  AST_END_CLR: assert property (
    ctl && pwdata[8] && !rsr_fast |=> !end_irq_flag)
    else $error("end flag not cleared");
  AST_TO_CLR: assert property (
    ctl && pwdata[9] && !rsr_fast |=> !timeout_irq_flag)
    else $error("timeout flag not cleared");
  AST_END_SET: assert property (
    $rose(end_irq_flag) |-> $past(rsr_fast) || $past(rsr_fast, 2))
    else $error("end flag outside a run");
  AST_DIV: assert property (
    $changed({divisor_high_latch, divisor_low_latch}) |->
    $past(wr && paddr == `UAB_ADDR_DIVISOR) || $past(rsr_fast)
    || $past(rsr_fast, 2)) else $error("divisor changed idle");
  AST_FRAC: assert property (
    $changed(frac_enable) |-> $past(wr && paddr == `UAB_ADDR_FRAC))
    else $error("frac enable moved alone");
endmodule // uab_autobaud_asserts
bind uab_autobaud uab_autobaud_asserts uab_autobaud_asserts_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .rsr_clear,
  .rsr_fast, .rsr_sample_pulse, .divisor_low_latch, .divisor_high_latch,
  .frac_enable, .end_irq_flag, .timeout_irq_flag);

// ===== bench/uab_rx_line.sv
/* Remote sender: one 8N1 character per send pulse.
   Assumes send is raised for one pclk cycle while idle. */
module uab_rx_line (
  input  wire logic        pclk,
  input  wire logic        send,
  input  wire logic [7:0]  chr,
  input  wire logic [15:0] bit_cycles,
  output logic             rxd,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] frame;
  // Line idles at mark, as a pulled-up receive pin would
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (send) begin
        busy <= 1'b1;
        frame = {1'b1, chr, 1'b0};
        for (int i = 0; i < 10; i++) begin
          rxd <= frame[i];
          repeat (bit_cycles) @(posedge pclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // uab_rx_line

// ===== bench/uab_autobaud_bench.sv
/* Bench for the auto-baud block: APB tasks and a remote sender.
   Assumes the defines header on the include path. */
`include "uab_defines.vh"
module uab_autobaud_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rxd, send, rx_busy, rsr_clear, rsr_fast, rsr_sample_pulse;
  logic        frac_enable, end_irq_flag, timeout_irq_flag, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0]  divisor_low_latch, divisor_high_latch, chr;
  logic [15:0] bit_cycles;
  int          num_errors = 0, n_checks = 0, n_pulse = 0;
  uab_autobaud uab_autobaud_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .rsr_clear,
    .rsr_fast, .rsr_sample_pulse, .divisor_low_latch, .divisor_high_latch,
    .frac_enable, .end_irq_flag, .timeout_irq_flag);
  uab_rx_line uab_rx_line_i (.pclk, .send, .chr, .bit_cycles, .rxd,
    .busy(rx_busy));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (rsr_clear) n_pulse <= 0;
    else if (rsr_sample_pulse) n_pulse <= n_pulse + 1;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the access's register updates land before callers look
    @(posedge pclk);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bit time is 16*d pclk, so the latches should read d, give or
  // take one prescaler tick of phase
  task automatic measure(input logic [31:0] ctl, input logic [7:0] c,
                         input logic en, input int d);
    logic ok;
    chr <= c;
    bit_cycles <= 16'(d * 16);
    apb(`UAB_ADDR_DIVISOR, 1'b1, 32'h0000_0000);
    apb(`UAB_ADDR_IRQ_EN, 1'b1, {31'h0, en});
    apb(`UAB_ADDR_CONTROL, 1'b1, ctl);
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    @(posedge pclk);
    for (int k = 0; k < 4000 && rsr_fast !== 1'b0; k++) @(posedge pclk);
    ok = {divisor_high_latch, divisor_low_latch} >= d - 1 &&
         {divisor_high_latch, divisor_low_latch} <= d + 1;
    chk(ok, 1'b1, "divisor");
    chk(n_pulse, 16, "pulses");
    chk(end_irq_flag, en, "end flag");
    apb(`UAB_ADDR_IRQ_ID, 1'b0, 32'h0000_0000);
    chk(rd, {31'h0, en}, "irq id");
    apb(`UAB_ADDR_CONTROL, 1'b0, 32'h0000_0000);
    chk(rd, ctl & 32'h0000_0006, "control");
    apb(`UAB_ADDR_CONTROL, 1'b1, 32'h0000_0300);
    chk(end_irq_flag, 1'b0, "end clear");
    chk(timeout_irq_flag, 1'b0, "no timeout");
    for (int k = 0; k < 4000 && rx_busy !== 1'b0; k++) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, send, presetn} = 5'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    chr = 8'h41;
    bit_cycles = 16'h00C0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(`UAB_ADDR_SCRATCH, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "scratch reset");
    apb(`UAB_ADDR_CONTROL, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "control reset");
    apb(`UAB_ADDR_SCRATCH, 1'b1, 32'h0000_00A5);
    apb(`UAB_ADDR_SCRATCH, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_00A5, "scratch");
    chk({end_irq_flag, timeout_irq_flag}, 2'h0, "scratch flags");
    apb(32'h4000_8024, 1'b0, 32'h0000_0000);
    chk(err, 1'b1, "unmapped");
    apb(`UAB_ADDR_FRAC, 1'b1, 32'h0000_0003);
    chk(frac_enable, 1'b1, "frac on");
    apb(`UAB_ADDR_FRAC, 1'b1, 32'h0000_0000);
    chk(frac_enable, 1'b0, "frac off");
    apb(`UAB_ADDR_CONTROL, 1'b1, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(rsr_fast, 1'b1, "fast rate");
    apb(`UAB_ADDR_CONTROL, 1'b1, 32'h0000_0000);
    apb(`UAB_ADDR_CONTROL, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "abort");
    chk(rsr_fast, 1'b0, "abort rate");
    measure(32'h0000_0003, 8'h41, 1'b1, 12);
    measure(32'h0000_0001, 8'h61, 1'b1, 13);
    measure(32'h0000_0005, 8'h41, 1'b0, 11);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
endmodule // uab_autobaud_bench
